/* scpi_ctrl_model.sv */
// controller-side model: clock pair, command, gate and strobe pins
`timescale 1ns/100ps
module scpi_ctrl_model (
    output logic       diffClockTrue,
    output logic       diffClockComp,
    output logic       clockGate,
    output logic       chipSelectN,
    output logic       rowStrobeN,
    output logic       colStrobeN,
    output logic       writeStrobeN,
    output logic [2:0] bankAddr,
    output logic       precharge_all_bit,
    output logic       termination_control,
    output logic       cfgTermOffBit,
    output logic       cfgStrobeModeBit,
    output logic       lower_data_strobe,
    output logic       upper_data_strobe,
    output logic       lower_byte_mask,
    output logic       upper_byte_mask
);
    logic ckRun = 1'b1;

    assign diffClockComp = ~diffClockTrue;

    initial begin
        {clockGate, chipSelectN, rowStrobeN, colStrobeN, writeStrobeN} = 5'h1F;
        {bankAddr, precharge_all_bit} = 4'h0;
        {termination_control, cfgTermOffBit, cfgStrobeModeBit} = 3'h0;
        {lower_data_strobe, upper_data_strobe, lower_byte_mask, upper_byte_mask} = 4'h0;
        diffClockTrue = 1'b0;
        // pair edges land just after a system clock edge, like other stimulus
        #11;
        forever begin
            #80;
            if (ckRun) diffClockTrue = ~diffClockTrue;
        end
    end

    task automatic send(input logic csN, input logic [2:0] code, input logic [2:0] ba,
                        input logic pall, input logic gate);
        @(negedge diffClockTrue);
        chipSelectN = csN;
        {rowStrobeN, colStrobeN, writeStrobeN} = code;
        bankAddr = ba;
        precharge_all_bit = pall;
        clockGate = gate;
        @(negedge diffClockTrue);
        chipSelectN = 1'b1;
        {rowStrobeN, colStrobeN, writeStrobeN} = scpi_pkg::CMD_NOP;
        // released lines show the inverse, not the old value
        bankAddr = ~ba;
        precharge_all_bit = ~pall;
    endtask : send

    task automatic wake();
        ckRun = 1'b0;
        #300;
        clockGate = 1'b1;
    endtask : wake

    task automatic aux(input logic t, input logic off, input logic stb);
        termination_control = t;
        cfgTermOffBit = off;
        cfgStrobeModeBit = stb;
    endtask : aux

    // mask valid around each strobe edge
    task automatic strobe(input logic m);
        {lower_byte_mask, upper_byte_mask} = {m, m};
        #20;
        lower_data_strobe = ~lower_data_strobe;
        upper_data_strobe = ~upper_data_strobe;
        #60;
        {lower_byte_mask, upper_byte_mask} = {~m, ~m};
        #40;
    endtask : strobe
endmodule : scpi_ctrl_model

/* scpi_device.sv */
// device-side control pin logic of a ddr2 sdram
`timescale 1ns/100ps
module scpi_device #(
    parameter logic [1:0] ORGANISATION = scpi_pkg::ORG_X8
) (
    input  wire logic                          clock,
    input  wire logic                          reset,
    input  wire logic                          diffClockTrue,
    input  wire logic                          diffClockComp,
    input  wire logic                          clockGate,
    input  wire logic                          chipSelectN,
    input  wire logic                          rowStrobeN,
    input  wire logic                          colStrobeN,
    input  wire logic                          writeStrobeN,
    input  wire logic [2:0]                    bankAddr,
    input  wire logic                          precharge_all_bit,
    input  wire logic                          termination_control,
    input  wire logic                          cfgTermOffBit,
    input  wire logic                          cfgStrobeModeBit,
    input  wire logic                          lower_data_strobe,
    input  wire logic                          upper_data_strobe,
    input  wire logic                          lower_byte_mask,
    input  wire logic                          upper_byte_mask,
    output logic                               cmdValid_r,
    output logic [2:0]                         cmdCode_r,
    output logic [scpi_pkg::NUM_BANKS-1:0]     bankOpen_r,
    output scpi_pkg::scpi_pwr_t                powerState_r,
    output logic                               internalClockOn_r,
    output logic                               outputDriveOn_r,
    output logic                               cmdBufOn_r,
    output logic                               clockBufOn_r,
    output logic                               readEdge_r,
    output logic                               termOn_r,
    output logic [scpi_pkg::TT_WIDTH-1:0]      termTargets_r,
    output logic                               strobeMode_r,
    output logic [scpi_pkg::NUM_LANES-1:0]     laneSample_r,
    output logic [scpi_pkg::NUM_LANES-1:0]     laneStore_r
);
    localparam int W = scpi_pkg::PIN_WIDTH;

    function automatic logic isWide(input logic [1:0] org);
        isWide = (org == scpi_pkg::ORG_X16);
    endfunction : isWide

    logic [W-1:0]  pinS1_r;
    logic [W-1:0]  pinS2_r;
    logic [3:0]    edgePrev_r;
    logic          termDisable_r;
    logic          writeActive_r;

    // every pin crosses two flops; only stage two is read
    // no reset: tracking the pins through reset avoids a false edge after it
    always_ff @(posedge clock) begin
        pinS1_r <= {upper_byte_mask, lower_byte_mask, upper_data_strobe,
                    lower_data_strobe, cfgStrobeModeBit, cfgTermOffBit,
                    termination_control, precharge_all_bit, bankAddr,
                    rowStrobeN, colStrobeN, writeStrobeN, chipSelectN,
                    clockGate, diffClockComp, diffClockTrue};
        pinS2_r <= pinS1_r;
    end

    always_ff @(posedge clock) begin
        edgePrev_r <= {pinS2_r[scpi_pkg::PIN_STB_LO+1], pinS2_r[scpi_pkg::PIN_STB_LO],
                       pinS2_r[scpi_pkg::PIN_CK_C], pinS2_r[scpi_pkg::PIN_CK_T]};
    end

    logic       ckT;
    logic       ckC;
    logic       gate;
    logic       clkRise;
    logic       clkFall;
    logic [2:0] cmd;
    logic [2:0] ba;
    logic       allIdle;
    logic       selected;

    assign ckT  = pinS2_r[scpi_pkg::PIN_CK_T];
    assign ckC  = pinS2_r[scpi_pkg::PIN_CK_C];
    assign gate = pinS2_r[scpi_pkg::PIN_GATE];
    assign cmd  = pinS2_r[scpi_pkg::PIN_CMD_LO+2:scpi_pkg::PIN_CMD_LO];
    assign ba   = pinS2_r[scpi_pkg::PIN_BA_LO+2:scpi_pkg::PIN_BA_LO];
    assign clkRise = ckT & ~edgePrev_r[0] & ~ckC;
    assign clkFall = ~ckT & edgePrev_r[0] & ckC;
    assign allIdle = (bankOpen_r == '0);
    assign selected = clkRise & ~pinS2_r[scpi_pkg::PIN_CS_N]
                      & (powerState_r == scpi_pkg::PS_ACTIVE);

    always_ff @(posedge clock) begin
        if (reset) begin
            cmdValid_r <= 1'b0;
            cmdCode_r  <= scpi_pkg::CMD_NOP;
        end else begin
            cmdValid_r <= selected & gate & (cmd != scpi_pkg::CMD_NOP);
            cmdCode_r  <= selected ? cmd : scpi_pkg::CMD_NOP;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            bankOpen_r <= '0;
        end else if (selected && gate && cmd == scpi_pkg::CMD_ACT) begin
            bankOpen_r[ba] <= 1'b1;
        end else if (selected && gate && cmd == scpi_pkg::CMD_PRE) begin
            if (pinS2_r[scpi_pkg::PIN_PALL]) begin
                bankOpen_r <= '0;
            end else begin
                bankOpen_r[ba] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            powerState_r <= scpi_pkg::PS_ACTIVE;
        end else begin
            unique case (powerState_r)
                scpi_pkg::PS_ACTIVE: begin
                    // entry only on a clock crossing
                    if (clkRise && !gate) begin
                        if (!allIdle) begin
                            powerState_r <= scpi_pkg::PS_PD_ACT;
                        end else if (selected && cmd == scpi_pkg::CMD_REF) begin
                            powerState_r <= scpi_pkg::PS_SELF;
                        end else begin
                            powerState_r <= scpi_pkg::PS_PD_PRE;
                        end
                    end
                end
                scpi_pkg::PS_PD_PRE, scpi_pkg::PS_PD_ACT: begin
                    if (clkRise && gate) begin
                        powerState_r <= scpi_pkg::PS_ACTIVE;
                    end
                end
                scpi_pkg::PS_SELF: begin
                    if (gate) begin
                        powerState_r <= scpi_pkg::PS_ACTIVE;
                    end
                end
                default: powerState_r <= scpi_pkg::PS_ACTIVE;
            endcase
        end
    end

    // buffer gating from the state and the gate level
    always_ff @(posedge clock) begin
        if (reset) begin
            internalClockOn_r <= 1'b1;
            outputDriveOn_r   <= 1'b1;
            cmdBufOn_r        <= 1'b1;
            clockBufOn_r      <= 1'b1;
        end else begin
            // gate level drives clocks and drivers
            internalClockOn_r <= gate;
            outputDriveOn_r   <= gate && powerState_r == scpi_pkg::PS_ACTIVE;
            cmdBufOn_r        <= powerState_r == scpi_pkg::PS_ACTIVE;
            // clock buffers off in self refresh
            clockBufOn_r      <= powerState_r != scpi_pkg::PS_SELF;
        end
    end

    // read data referenced to both crossings
    always_ff @(posedge clock) begin
        if (reset) begin
            readEdge_r <= 1'b0;
        end else begin
            readEdge_r <= (clkRise | clkFall) & outputDriveOn_r;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            termDisable_r <= scpi_pkg::RST_TERM_DISABLE;
            strobeMode_r  <= scpi_pkg::RST_STROBE_MODE;
        end else if (selected && gate && cmd == scpi_pkg::CMD_MRS
                     && ba == scpi_pkg::BA_EXT_ONE) begin
            termDisable_r <= pinS2_r[scpi_pkg::PIN_CFG_T];
            strobeMode_r  <= pinS2_r[scpi_pkg::PIN_CFG_S]
                             & (ORGANISATION == scpi_pkg::ORG_X8);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            termOn_r <= 1'b0;
        end else if (termDisable_r) begin
            termOn_r <= 1'b0;
        end else if (clkRise && powerState_r == scpi_pkg::PS_ACTIVE) begin
            // termination input buffer is off outside the active state
            termOn_r <= pinS2_r[scpi_pkg::PIN_TERM];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            termTargets_r <= '0;
        end else begin
            termTargets_r <= '0;
            if (termOn_r) begin
                termTargets_r[scpi_pkg::TT_DATA]  <= 1'b1;
                termTargets_r[scpi_pkg::TT_STB_L] <= 1'b1;
                termTargets_r[scpi_pkg::TT_MASK0] <= 1'b1;
                termTargets_r[scpi_pkg::TT_RDSTB] <= !isWide(ORGANISATION);
                termTargets_r[scpi_pkg::TT_STB_U] <= isWide(ORGANISATION);
                termTargets_r[scpi_pkg::TT_MASK1] <= isWide(ORGANISATION);
            end
        end
    end

    // write access window: opened by write, closed by any other command except NOP
    always_ff @(posedge clock) begin
        if (reset) begin
            writeActive_r <= 1'b0;
        end else if (powerState_r != scpi_pkg::PS_ACTIVE) begin
            writeActive_r <= 1'b0;
        end else if (selected && gate && cmd != scpi_pkg::CMD_NOP) begin
            writeActive_r <= (cmd == scpi_pkg::CMD_WR);
        end
    end

    // per-lane mask sampling on both strobe edges
    for (genvar i = 0; i < scpi_pkg::NUM_LANES; i++) begin : g_lane
        logic stbEdge;
        logic laneUsed;
        assign stbEdge  = pinS2_r[scpi_pkg::PIN_STB_LO+i] ^ edgePrev_r[2+i];
        assign laneUsed = (i == 0) || isWide(ORGANISATION);
        always_ff @(posedge clock) begin
            if (reset) begin
                laneSample_r[i] <= 1'b0;
                laneStore_r[i]  <= 1'b0;
            end else begin
                laneSample_r[i] <= stbEdge & writeActive_r & laneUsed;
                laneStore_r[i]  <= stbEdge & writeActive_r & laneUsed
                                   & (strobeMode_r | ~pinS2_r[scpi_pkg::PIN_MASK_LO+i]);
            end
        end
        a_mask_blocks: assert property (@(posedge clock) disable iff (reset)
            (stbEdge && !strobeMode_r && pinS2_r[scpi_pkg::PIN_MASK_LO+i]) |=> !laneStore_r[i])
            else $error("masked write item stored");
    end

    a_cs_masks: assert property (@(posedge clock) disable iff (reset)
        (clkRise && pinS2_r[scpi_pkg::PIN_CS_N]) |=> !cmdValid_r)
        else $error("command taken with select high");
    a_cmd_edge: assert property (@(posedge clock) disable iff (reset)
        cmdValid_r |-> $past(clkRise))
        else $error("command outside clock crossing");
    a_pd_active: assert property (@(posedge clock) disable iff (reset)
        (powerState_r == scpi_pkg::PS_ACTIVE && clkRise && !gate && !allIdle)
        |=> powerState_r == scpi_pkg::PS_PD_ACT)
        else $error("open row did not give active power-down");
    a_sr_exit: assert property (@(posedge clock) disable iff (reset)
        (powerState_r == scpi_pkg::PS_SELF && gate) |=> powerState_r == scpi_pkg::PS_ACTIVE)
        else $error("self refresh exit waited");
    a_pd_bufs: assert property (@(posedge clock) disable iff (reset)
        (powerState_r == scpi_pkg::PS_PD_PRE) [*2] |-> !cmdBufOn_r && clockBufOn_r)
        else $error("power-down buffer gating wrong");
    a_sr_bufs: assert property (@(posedge clock) disable iff (reset)
        (powerState_r == scpi_pkg::PS_SELF) [*2] |-> !clockBufOn_r && !cmdBufOn_r)
        else $error("self refresh buffer gating wrong");
    a_gate_clock: assert property (@(posedge clock) disable iff (reset)
        $fell(gate) |=> !internalClockOn_r)
        else $error("internal clock still on");
    a_term_off: assert property (@(posedge clock) disable iff (reset)
        termDisable_r |=> !termOn_r ##1 termTargets_r == '0)
        else $error("termination while disabled");
    a_pre_all: assert property (@(posedge clock) disable iff (reset)
        (selected && gate && cmd == scpi_pkg::CMD_PRE && pinS2_r[scpi_pkg::PIN_PALL])
        |=> bankOpen_r == '0)
        else $error("precharge all left a bank open");
    a_read_edge: assert property (@(posedge clock) disable iff (reset)
        readEdge_r |-> $past(clkRise || clkFall))
        else $error("read edge without crossing");
endmodule : scpi_device

/* scpi_pkg.sv */
// constants and types for the sdram control pin interface
package scpi_pkg;
    // organisation codes
    localparam logic [1:0] ORG_X4  = 2'h0;
    localparam logic [1:0] ORG_X8  = 2'h1;
    localparam logic [1:0] ORG_X16 = 2'h2;

    localparam int NUM_BANKS   = 8;
    localparam int NUM_LANES   = 2;
    localparam int SYNC_STAGES = 2;

    // command codes on {row, column, write} strobes, active low
    localparam logic [2:0] CMD_MRS = 3'h0;
    localparam logic [2:0] CMD_REF = 3'h1;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_WR  = 3'h4;
    localparam logic [2:0] CMD_RD  = 3'h5;
    localparam logic [2:0] CMD_NOP = 3'h7;

    // bank address that selects the first extended configuration register
    localparam logic [2:0] BA_EXT_ONE = 3'h1;

    // positions in the synchronised pin vector
    localparam int PIN_CK_T    = 0;
    localparam int PIN_CK_C    = 1;
    localparam int PIN_GATE    = 2;
    localparam int PIN_CS_N    = 3;
    localparam int PIN_CMD_LO  = 4;
    localparam int PIN_BA_LO   = 7;
    localparam int PIN_PALL    = 10;
    localparam int PIN_TERM    = 11;
    localparam int PIN_CFG_T   = 12;
    localparam int PIN_CFG_S   = 13;
    localparam int PIN_STB_LO  = 14;
    localparam int PIN_MASK_LO = 16;
    localparam int PIN_WIDTH   = 18;

    // termination target vector positions
    localparam int TT_DATA  = 0;
    localparam int TT_STB_L = 1;
    localparam int TT_RDSTB = 2;
    localparam int TT_MASK0 = 3;
    localparam int TT_STB_U = 4;
    localparam int TT_MASK1 = 5;
    localparam int TT_WIDTH = 6;

    // reset values
    localparam logic RST_TERM_DISABLE = 1'b0;
    localparam logic RST_STROBE_MODE  = 1'b0;

    typedef enum logic [3:0] {
        PS_ACTIVE = 4'h1,
        PS_PD_PRE = 4'h2,
        PS_PD_ACT = 4'h4,
        PS_SELF   = 4'h8
    } scpi_pwr_t;
endpackage : scpi_pkg

/* tb.sv */
// self-checking bench for the control pin interface
`timescale 1ns/100ps
module tb;
    logic clock, reset, ckT, ckC, gate, csN, rasN, casN, weN, pall, term, cOff, cStb;
    logic dqsL, dqsU, dmL, dmU, cmdValid_r, internalClockOn_r, outputDriveOn_r;
    logic cmdBufOn_r, clockBufOn_r, readEdge_r, termOn_r, strobeMode_r;
    logic [2:0] ba, cmdCode_r, lastCode;
    logic [7:0] bankOpen_r;
    logic [5:0] termTargets_r;
    logic [1:0] laneSample_r, laneStore_r;
    scpi_pkg::scpi_pwr_t powerState_r;
    int fails = 0;
    int n_checks = 0;
    int vCnt = 0, sCnt = 0, kCnt = 0, uCnt = 0, eCnt = 0;

    scpi_ctrl_model scpi_ctrl_model_inst (.diffClockTrue(ckT), .diffClockComp(ckC),
        .clockGate(gate), .chipSelectN(csN), .rowStrobeN(rasN), .colStrobeN(casN),
        .writeStrobeN(weN), .bankAddr(ba), .precharge_all_bit(pall), .termination_control(term),
        .cfgTermOffBit(cOff), .cfgStrobeModeBit(cStb), .lower_data_strobe(dqsL),
        .upper_data_strobe(dqsU), .lower_byte_mask(dmL), .upper_byte_mask(dmU));

    scpi_device scpi_device_inst (.clock(clock), .reset(reset), .diffClockTrue(ckT),
        .diffClockComp(ckC), .clockGate(gate), .chipSelectN(csN), .rowStrobeN(rasN),
        .colStrobeN(casN), .writeStrobeN(weN), .bankAddr(ba), .precharge_all_bit(pall),
        .termination_control(term), .cfgTermOffBit(cOff), .cfgStrobeModeBit(cStb),
        .lower_data_strobe(dqsL), .upper_data_strobe(dqsU), .lower_byte_mask(dmL),
        .upper_byte_mask(dmU), .cmdValid_r(cmdValid_r), .cmdCode_r(cmdCode_r),
        .bankOpen_r(bankOpen_r), .powerState_r(powerState_r),
        .internalClockOn_r(internalClockOn_r), .outputDriveOn_r(outputDriveOn_r),
        .cmdBufOn_r(cmdBufOn_r), .clockBufOn_r(clockBufOn_r), .readEdge_r(readEdge_r),
        .termOn_r(termOn_r), .termTargets_r(termTargets_r), .strobeMode_r(strobeMode_r),
        .laneSample_r(laneSample_r), .laneStore_r(laneStore_r));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // pulses are counted mid-cycle, where every one-cycle output has settled
    always @(negedge clock) begin
        if (cmdValid_r === 1'b1) begin
            vCnt++;
            lastCode = cmdCode_r;
        end
        if (laneSample_r[0] === 1'b1) sCnt++;
        if (laneStore_r[0] === 1'b1) kCnt++;
        if (laneSample_r[1] !== 1'b0 || laneStore_r[1] !== 1'b0) uCnt++;
        if (readEdge_r === 1'b1) eCnt++;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : settle

    task automatic cmd(input logic c, input logic [2:0] k, input logic [2:0] b,
                       input logic p, input logic g);
        scpi_ctrl_model_inst.send(c, k, b, p, g);
        settle(6);
    endtask : cmd

    task automatic t_reset();
        chk(8'(cmdCode_r), 8'h07);
        chk(bankOpen_r, 8'h00);
        chk(8'(powerState_r), 8'(scpi_pkg::PS_ACTIVE));
        chk(8'({cmdBufOn_r, clockBufOn_r, outputDriveOn_r, termOn_r}), 8'h0E);
        eCnt = 0;
        settle(32);
        chk(8'(eCnt), 8'h08);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_cmd();
        logic [2:0] codes [6] = '{scpi_pkg::CMD_ACT, scpi_pkg::CMD_RD, scpi_pkg::CMD_WR,
            scpi_pkg::CMD_PRE, scpi_pkg::CMD_REF, scpi_pkg::CMD_MRS};
        for (int i = 0; i < 6; i++) begin
            vCnt = 0;
            cmd(1'b0, codes[i], 3'h3, 1'b0, 1'b1);
            chk(8'(vCnt), 8'h01);
            chk(8'(lastCode), 8'(codes[i]));
            if (i == 0) chk(bankOpen_r, 8'h08);
        end
        chk(bankOpen_r, 8'h00);
        vCnt = 0;
        cmd(1'b1, scpi_pkg::CMD_ACT, 3'h6, 1'b0, 1'b1);
        chk(8'(vCnt) | bankOpen_r, 8'h00);
        cmd(1'b0, scpi_pkg::CMD_ACT, 3'h2, 1'b0, 1'b1);
        cmd(1'b0, scpi_pkg::CMD_ACT, 3'h5, 1'b0, 1'b1);
        cmd(1'b0, scpi_pkg::CMD_PRE, 3'h2, 1'b0, 1'b1);
        chk(bankOpen_r, 8'h20);
        cmd(1'b0, scpi_pkg::CMD_PRE, 3'h0, 1'b1, 1'b1);
        chk(bankOpen_r, 8'h00);
        $display("t_cmd done");
    endtask : t_cmd

    task automatic t_power();
        cmd(1'b0, scpi_pkg::CMD_ACT, 3'h1, 1'b0, 1'b1);
        cmd(1'b1, scpi_pkg::CMD_NOP, 3'h0, 1'b0, 1'b0);
        chk(8'(powerState_r), 8'(scpi_pkg::PS_PD_ACT));
        chk(8'({cmdBufOn_r, clockBufOn_r, outputDriveOn_r, internalClockOn_r}), 8'h04);
        cmd(1'b1, scpi_pkg::CMD_NOP, 3'h0, 1'b0, 1'b1);
        chk(8'({powerState_r, internalClockOn_r}), 8'h03);
        cmd(1'b0, scpi_pkg::CMD_PRE, 3'h0, 1'b1, 1'b1);
        cmd(1'b1, scpi_pkg::CMD_NOP, 3'h0, 1'b0, 1'b0);
        chk(8'(powerState_r), 8'(scpi_pkg::PS_PD_PRE));
        cmd(1'b1, scpi_pkg::CMD_NOP, 3'h0, 1'b0, 1'b1);
        cmd(1'b0, scpi_pkg::CMD_REF, 3'h0, 1'b0, 1'b0);
        chk(8'(powerState_r), 8'(scpi_pkg::PS_SELF));
        chk(8'({cmdBufOn_r, clockBufOn_r}), 8'h00);
        scpi_ctrl_model_inst.wake();
        settle(6);
        chk(8'(powerState_r), 8'(scpi_pkg::PS_ACTIVE));
        scpi_ctrl_model_inst.ckRun = 1'b1;
        $display("t_power done");
    endtask : t_power

    task automatic t_term();
        scpi_ctrl_model_inst.aux(1'b1, 1'b0, 1'b0);
        cmd(1'b1, scpi_pkg::CMD_NOP, 3'h0, 1'b0, 1'b1);
        chk(8'({termOn_r, termTargets_r}), 8'h4F);
        scpi_ctrl_model_inst.aux(1'b0, 1'b1, 1'b0);
        cmd(1'b0, scpi_pkg::CMD_MRS, scpi_pkg::BA_EXT_ONE, 1'b0, 1'b1);
        chk(8'(termOn_r), 8'h00);
        scpi_ctrl_model_inst.aux(1'b1, 1'b0, 1'b0);
        cmd(1'b1, scpi_pkg::CMD_NOP, 3'h0, 1'b0, 1'b1);
        chk(8'(termOn_r), 8'h00);
        scpi_ctrl_model_inst.aux(1'b0, 1'b0, 1'b0);
        cmd(1'b0, scpi_pkg::CMD_MRS, scpi_pkg::BA_EXT_ONE, 1'b0, 1'b1);
        $display("t_term done");
    endtask : t_term

    task automatic t_write();
        cmd(1'b0, scpi_pkg::CMD_WR, 3'h0, 1'b0, 1'b1);
        {sCnt, kCnt, uCnt} = '0;
        scpi_ctrl_model_inst.strobe(1'b1);
        scpi_ctrl_model_inst.strobe(1'b0);
        settle(4);
        chk(8'(sCnt), 8'h02);
        chk(8'(kCnt), 8'h01);
        chk(8'(uCnt), 8'h00);
        scpi_ctrl_model_inst.aux(1'b0, 1'b0, 1'b1);
        cmd(1'b0, scpi_pkg::CMD_MRS, scpi_pkg::BA_EXT_ONE, 1'b0, 1'b1);
        chk(8'(strobeMode_r), 8'h01);
        cmd(1'b0, scpi_pkg::CMD_WR, 3'h0, 1'b0, 1'b1);
        kCnt = 0;
        scpi_ctrl_model_inst.strobe(1'b1);
        settle(4);
        chk(8'(kCnt), 8'h01);
        $display("t_write done");
    endtask : t_write

    task automatic results();
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results

    initial begin
        reset = 1'b1;
        settle(6);
        reset = 1'b0;
        t_reset();
        t_cmd();
        t_power();
        t_term();
        t_write();
        results();
    end

    // whole run is about 10 us; far beyond that means a hang
    initial begin
        #400000;
        fails++;
        results();
    end
endmodule : tb
